// ==== setwt_pkg.sv ====
// Shared constants and types for the two-wire serial EEPROM target
package setwt_pkg;

    // Fixed device address prefix in the top nibble
    localparam logic [3:0] DEV_PREFIX = 4'hA;
    // Bit positions inside the device address byte
    localparam int DEV_RW_BIT = 0;
    // Bits counted in one serial word before its acknowledge slot
    localparam logic [3:0] WORD_BITS = 4'h8;
    // Widest supported memory address and page
    localparam int ADDR_W_MAX = 10;
    localparam int PAGE_MAX = 16;
    // Page index widths for small and large densities
    localparam int PAGE_W_SMALL = 3;
    localparam int PAGE_W_LARGE = 4;
    // Default density in kbit
    localparam int DENSITY_DEF = 2;
    // Self-timed programming cycle, longest time
    localparam int WR_TIME_US = 5000;
    localparam int MCLK_KHZ = 10000;
    localparam int WR_CYCLES = WR_TIME_US * MCLK_KHZ / 1000;
    localparam int TMR_W = 16;
    // Reset values
    localparam logic [ADDR_W_MAX-1:0] ADDR_RST = 10'h000;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

    // Link-side protocol states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_DEVADDR = 4'b0001,
        ST_DEV_ACK = 4'b0010,
        ST_WORD    = 4'b0011,
        ST_WA_ACK  = 4'b0100,
        ST_WDATA   = 4'b0101,
        ST_WD_ACK  = 4'b0110,
        ST_RDATA   = 4'b0111,
        ST_RD_ACK  = 4'b1000
    } setwt_state_t;

endpackage

// ==== setwt_sync.sv ====
// Two-flop level synchroniser, any width
`timescale 1ns/10ps
`default_nettype none

module setwt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end

endmodule

`default_nettype wire

// ==== setwt_top.sv ====
// Two-wire serial EEPROM target: link protocol engine, array and write timer
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R01 - Select needs device prefix 1010 after Start
// R02 - Small sizes compare all three strap bits
// R03 - Mid size: two straps, low bit addresses
// R04 - Large size: one strap, two page bits
// R05 - Last device bit: one read, zero write
// R06 - Match acknowledges low; mismatch returns idle
// R07 - Byte write: word address, data, Stop
// R08 - Stop starts programming; bus ignored meanwhile
// R09 - Page write of 8 or 16 bytes
// R10 - Every received data byte acknowledged low while write inhibit is low
// R11 - Write address wraps inside its page
// R12 - Polling acknowledged only after programming ends
// R13 - Address counter keeps last address plus one
// R14 - Read address wraps over whole memory
// R15 - Current read sends byte at counter
// R16 - Random read uses dummy write first
// R17 - Controller acknowledge advances sequential read
// R18 - Programming cycle lasts at most 5 ms
// R19 - Write inhibit high blocks all writes
// R20 - Ninth clock carries the acknowledge
// R21 - Data edge with clock high frames
// R22 - Partial write byte is discarded
module setwt_top #(
    parameter int DENSITY_KBIT = setwt_pkg::DENSITY_DEF,
    parameter int WR_CYCLES = setwt_pkg::WR_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic strap_select_bit_2,
    input wire logic strap_select_bit_1,
    input wire logic strap_select_bit_0,
    input wire logic write_inhibit,
    output logic prog_busy
);

    localparam int AW = (DENSITY_KBIT <= 1) ? 7 : (DENSITY_KBIT == 2) ? 8 :
                        (DENSITY_KBIT == 4) ? 9 : 10;
    localparam int PW = (DENSITY_KBIT <= 2) ? setwt_pkg::PAGE_W_SMALL :
                        setwt_pkg::PAGE_W_LARGE;
    localparam int MW = setwt_pkg::ADDR_W_MAX;
    localparam logic [MW-1:0] AMASK = MW'((1 << AW) - 1);
    localparam logic [MW-1:0] PMASK = MW'((1 << PW) - 1);

    // R01 prefix check
    // R02 R03 R04 strap compare by density
    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] strap);
        logic ok;
        ok = (b[7:4] == setwt_pkg::DEV_PREFIX);
        if (DENSITY_KBIT <= 2) begin
            ok = ok && (b[3:1] == strap);
        end else if (DENSITY_KBIT == 4) begin
            ok = ok && (b[3:2] == strap[2:1]);
        end else begin
            ok = ok && (b[3] == strap[2]);
        end
        return ok;
    endfunction

    // R03 R04 memory address bits carried in the device byte
    function automatic logic [1:0] dev_hi(input logic [7:0] b);
        logic [1:0] hi;
        hi = 2'h0;
        if (DENSITY_KBIT == 4) begin
            hi = {1'b0, b[1]};
        end else if (DENSITY_KBIT > 4) begin
            hi = b[2:1];
        end
        return hi;
    endfunction

    // ---------------- Link domain ----------------
    logic [5:0] pins_s;
    logic lrst;
    logic done_s;
    logic scl_s, sda_s, wp_s;
    logic [2:0] strap_s;

    // Pins pass two flops before any logic reads them
    setwt_sync #(.WIDTH(6)) u_pin_sync (
        .clk(link_clk),
        .d({scl_in, sda_in, write_inhibit, strap_select_bit_2,
            strap_select_bit_1, strap_select_bit_0}),
        .q(pins_s)
    );
    setwt_sync #(.WIDTH(1)) u_rst_sync (
        .clk(link_clk),
        .d(srst),
        .q(lrst)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    assign wp_s = pins_s[3];
    assign strap_s = pins_s[2:0];

    setwt_pkg::setwt_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic rw_r, rw_nxt;
    logic [1:0] hi_r, hi_nxt;
    logic [MW-1:0] addr_r, addr_nxt;
    logic oe_n_r, oe_n_nxt;
    logic pend_r, pend_nxt;
    logic busy_r, busy_nxt;
    logic [setwt_pkg::PAGE_MAX-1:0] mask_r, mask_nxt;
    logic ack_r, ack_nxt;
    logic req_tog_r, req_tog_nxt;
    logic done_q_r;
    logic scl_q_r, sda_q_r;
    logic buf_we, commit;
    logic [7:0] rd_byte;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic [MW-1:0] addr_full_inc, addr_page_inc;

    // Array and page buffer are plain memories without reset
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] page_buf [0:setwt_pkg::PAGE_MAX-1];

    // R21 framing and clock edges from the synchronised pins
    assign scl_rise = scl_s && !scl_q_r;
    assign scl_fall = !scl_s && scl_q_r;
    assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

    // R14 read wraps over all memory; R11 write wraps in page
    assign addr_full_inc = (addr_r + MW'(1)) & AMASK;
    assign addr_page_inc = (addr_r & ~PMASK) | ((addr_r + MW'(1)) & PMASK);
    assign rd_byte = mem[addr_r[AW-1:0]];

    // Next-state logic of the protocol engine
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        rw_nxt = rw_r;
        hi_nxt = hi_r;
        addr_nxt = addr_r;
        oe_n_nxt = oe_n_r;
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        mask_nxt = mask_r;
        ack_nxt = ack_r;
        req_tog_nxt = req_tog_r;
        buf_we = 1'b0;
        commit = 1'b0;
        // Timer finished in the system domain: program the page now
        if (done_s != done_q_r) begin
            commit = 1'b1;
            busy_nxt = 1'b0;
            mask_nxt = '0;
        end
        // Sample on rising clock edge
        if (scl_rise) begin
            case (state_r)
                setwt_pkg::ST_DEVADDR, setwt_pkg::ST_WORD, setwt_pkg::ST_WDATA: begin
                    shift_nxt = {shift_r[6:0], sda_s};
                    cnt_nxt = cnt_r + 4'h1;
                end
                setwt_pkg::ST_RDATA: begin
                    cnt_nxt = cnt_r + 4'h1;
                end
                // R17 controller acknowledge sampled
                setwt_pkg::ST_RD_ACK: begin
                    ack_nxt = !sda_s;
                end
                default: begin
                end
            endcase
        end
        // Drive or release on falling clock edge
        if (scl_fall) begin
            case (state_r)
                setwt_pkg::ST_DEVADDR: begin
                    if (cnt_r == setwt_pkg::WORD_BITS) begin
                        // R12 refuse selection while programming
                        // R06 acknowledge match, else standby
                        if (dev_match(shift_r, strap_s) && !busy_r) begin
                            oe_n_nxt = 1'b0;
                            // R05 direction bit
                            rw_nxt = shift_r[setwt_pkg::DEV_RW_BIT];
                            hi_nxt = dev_hi(shift_r);
                            state_nxt = setwt_pkg::ST_DEV_ACK;
                        end else begin
                            state_nxt = setwt_pkg::ST_IDLE;
                        end
                    end
                end
                setwt_pkg::ST_DEV_ACK, setwt_pkg::ST_RD_ACK: begin
                    cnt_nxt = 4'h0;
                    if (state_r == setwt_pkg::ST_RD_ACK && !ack_r) begin
                        // R17 no acknowledge ends the read
                        oe_n_nxt = 1'b1;
                        state_nxt = setwt_pkg::ST_IDLE;
                    end else if (state_r == setwt_pkg::ST_RD_ACK || rw_r) begin
                        // R13 send byte at counter, counter moves on
                        shift_nxt = rd_byte;
                        oe_n_nxt = rd_byte[7];
                        addr_nxt = addr_full_inc;
                        state_nxt = setwt_pkg::ST_RDATA;
                    end else begin
                        oe_n_nxt = 1'b1;
                        state_nxt = setwt_pkg::ST_WORD;
                    end
                end
                setwt_pkg::ST_RDATA: begin
                    if (cnt_r == setwt_pkg::WORD_BITS) begin
                        // R20 release for the controller acknowledge
                        oe_n_nxt = 1'b1;
                        ack_nxt = 1'b0;
                        state_nxt = setwt_pkg::ST_RD_ACK;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_n_nxt = shift_r[6];
                    end
                end
                setwt_pkg::ST_WORD: begin
                    if (cnt_r == setwt_pkg::WORD_BITS) begin
                        // R07 R16 word address loads the counter
                        addr_nxt = ({6'h00, hi_r, 2'h0} << 6 | {2'h0, shift_r}) & AMASK;
                        mask_nxt = '0;
                        oe_n_nxt = 1'b0;
                        state_nxt = setwt_pkg::ST_WA_ACK;
                    end
                end
                setwt_pkg::ST_WDATA: begin
                    if (cnt_r == setwt_pkg::WORD_BITS) begin
                        // R19 inhibited array takes no data
                        if (!wp_s) begin
                            // R09 R10 buffer and acknowledge each byte
                            buf_we = 1'b1;
                            mask_nxt[addr_r[PW-1:0]] = 1'b1;
                            pend_nxt = 1'b1;
                            // R11 in-page increment
                            addr_nxt = addr_page_inc;
                            oe_n_nxt = 1'b0;
                            state_nxt = setwt_pkg::ST_WD_ACK;
                        end else begin
                            oe_n_nxt = 1'b1;
                            state_nxt = setwt_pkg::ST_IDLE;
                        end
                    end
                end
                setwt_pkg::ST_WA_ACK, setwt_pkg::ST_WD_ACK: begin
                    oe_n_nxt = 1'b1;
                    cnt_nxt = 4'h0;
                    state_nxt = setwt_pkg::ST_WDATA;
                end
                default: begin
                end
            endcase
        end
        // R22 framing drops a partial byte; Start restarts addressing
        if (start_det) begin
            state_nxt = setwt_pkg::ST_DEVADDR;
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
            if (pend_r) begin
                pend_nxt = 1'b0;
                mask_nxt = '0;
            end
        end
        // R08 Stop after buffered data launches programming
        if (stop_det) begin
            state_nxt = setwt_pkg::ST_IDLE;
            oe_n_nxt = 1'b1;
            if (pend_r) begin
                pend_nxt = 1'b0;
                busy_nxt = 1'b1;
                req_tog_nxt = !req_tog_r;
            end
        end
    end

    // Link-domain registers
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            state_r <= setwt_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            hi_r <= 2'h0;
            addr_r <= setwt_pkg::ADDR_RST;
            oe_n_r <= 1'b1;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            mask_r <= '0;
            ack_r <= 1'b0;
            req_tog_r <= 1'b0;
            done_q_r <= 1'b0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            rw_r <= rw_nxt;
            hi_r <= hi_nxt;
            addr_r <= addr_nxt;
            oe_n_r <= oe_n_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            mask_r <= mask_nxt;
            ack_r <= ack_nxt;
            req_tog_r <= req_tog_nxt;
            done_q_r <= done_s;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // Open-drain pin: the level flop never leaves low, enable does the work
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= oe_n_nxt;
        end
    end

    // Page buffer and array writes; only acknowledged bytes are flagged
    always_ff @(posedge link_clk) begin
        if (buf_we) begin
            page_buf[addr_r[PW-1:0]] <= shift_r;
        end
        if (commit) begin
            for (int i = 0; i < (1 << PW); i++) begin
                if (mask_r[i]) begin
                    mem[AW'((addr_r & ~PMASK) | MW'(i))] <= page_buf[i];
                end
            end
        end
    end

    // ---------------- System-clock domain: write timer ----------------
    logic req_s;
    logic req_q_r, req_q_nxt;
    logic done_tog_r, done_tog_nxt;
    logic tbusy_r, tbusy_nxt;
    logic [setwt_pkg::TMR_W-1:0] tmr_r, tmr_nxt;

    setwt_sync #(.WIDTH(1)) u_req_sync (
        .clk(mclk),
        .d(req_tog_r),
        .q(req_s)
    );
    setwt_sync #(.WIDTH(1)) u_done_sync (
        .clk(link_clk),
        .d(done_tog_r),
        .q(done_s)
    );

    // R18 count the programming time, then hand completion back
    always_comb begin
        req_q_nxt = req_s;
        done_tog_nxt = done_tog_r;
        tbusy_nxt = tbusy_r;
        tmr_nxt = tmr_r;
        if (req_s != req_q_r) begin
            tbusy_nxt = 1'b1;
            tmr_nxt = setwt_pkg::TMR_W'(WR_CYCLES - 1);
        end else if (tbusy_r) begin
            if (tmr_r == setwt_pkg::TMR_RST) begin
                tbusy_nxt = 1'b0;
                done_tog_nxt = !done_tog_r;
            end else begin
                tmr_nxt = tmr_r - setwt_pkg::TMR_W'(1);
            end
        end
    end

    // Timer registers; busy output mirrors the timer flop
    always_ff @(posedge mclk) begin
        if (srst) begin
            req_q_r <= 1'b0;
            done_tog_r <= 1'b0;
            tbusy_r <= 1'b0;
            tmr_r <= setwt_pkg::TMR_RST;
            prog_busy <= 1'b0;
        end else begin
            req_q_r <= req_q_nxt;
            done_tog_r <= done_tog_nxt;
            tbusy_r <= tbusy_nxt;
            tmr_r <= tmr_nxt;
            prog_busy <= tbusy_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== setwt_top_assertions.sv ====
// Concurrent port checks for the two-wire EEPROM target
`timescale 1ns/10ps
`default_nettype none

module setwt_top_assertions #(
    parameter int WR_CYCLES = 50000
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic write_inhibit,
    input wire logic prog_busy
);
    logic [15:0] busy_cnt_r;
    logic [3:0] low_cnt_r;

    // Length of the current busy stretch
    always_ff @(posedge mclk) begin
        busy_cnt_r <= (srst || !prog_busy) ? 16'h0000 : busy_cnt_r + 16'h0001;
    end

    // Link cycles since bus clock went low; saturates so long stalls stay harmless
    always_ff @(posedge link_clk) begin
        if (srst || scl_in) begin
            low_cnt_r <= 4'h0;
        end else if (low_cnt_r != 4'hF) begin
            low_cnt_r <= low_cnt_r + 4'h1;
        end
    end

    sequence busy_start;
        !prog_busy ##1 prog_busy;
    endsequence

    sda_drive_a: assert property (
        @(posedge link_clk) disable iff (srst) !sda_oe_n |-> !sda_out && !sda_in)
        else $error("data pin driven high");
    ack_delay_a: assert property (
        @(posedge link_clk) disable iff (srst)
        $changed(sda_oe_n) |-> low_cnt_r >= 4'h2 && low_cnt_r <= 4'h7)
        else $error("data drive moved outside clock low");
    busy_len_a: assert property (
        @(posedge mclk) disable iff (srst)
        $fell(prog_busy) |-> busy_cnt_r >= WR_CYCLES && busy_cnt_r <= WR_CYCLES + 1)
        else $error("programming length wrong");
    busy_cap_a: assert property (
        @(posedge mclk) disable iff (srst) prog_busy |-> busy_cnt_r <= WR_CYCLES + 1)
        else $error("programming overran");
    busy_hold_a: assert property (
        @(posedge mclk) disable iff (srst) busy_start |-> prog_busy [*8])
        else $error("programming dropped early");
    busy_mute_a: assert property (
        @(posedge mclk) disable iff (srst) prog_busy |-> sda_oe_n)
        else $error("answer while programming");
    busy_idle_a: assert property (
        @(posedge mclk) disable iff (srst) busy_start |-> scl_in && sda_in)
        else $error("programming began on busy bus");
    wi_block_a: assert property (
        @(posedge mclk) disable iff (srst) busy_start |-> !write_inhibit)
        else $error("programming while inhibited");
    rst_quiet_a: assert property (
        @(posedge mclk) srst |=> !prog_busy && sda_oe_n)
        else $error("outputs active in reset");
endmodule

bind setwt_top setwt_top_assertions #(.WR_CYCLES(WR_CYCLES)) chk (
    .mclk(mclk), .srst(srst), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_inhibit(write_inhibit),
    .prog_busy(prog_busy));

`default_nettype wire

// ==== setwt_host.sv ====
// Bus controller model that drives the two-wire link from the bench clock
`timescale 1ns/10ps
`default_nettype none

module setwt_host (
    input wire logic mclk,
    input wire logic sda_w,
    output var logic scl,
    output var logic sda
);
    // Released lines read high through the pull-up
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Start framing: data falls while clock high
    task automatic start();
        step(2);
        sda <= 1'b1;
        step(2);
        scl <= 1'b1;
        step(4);
        sda <= 1'b0;
        step(4);
        scl <= 1'b0;
    endtask

    // Stop framing, then bus free time so nothing overlaps the next Start
    task automatic stop();
        step(2);
        sda <= 1'b0;
        step(2);
        scl <= 1'b1;
        step(4);
        sda <= 1'b1;
        step(8);
    endtask

    // One bit: data set mid-low, sampled mid-high
    task automatic xfer(input logic b, output logic s);
        step(2);
        sda <= b;
        step(2);
        scl <= 1'b1;
        step(2);
        s = sda_w;
        step(2);
        scl <= 1'b0;
    endtask

    // Byte out MSB first, line released on the ninth clock
    task automatic put(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) xfer(d[i], ack);
        xfer(1'b1, ack);
    endtask

    // Byte in; low on the ninth clock continues, high ends
    task automatic get(input logic nack, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, q[i]);
        xfer(nack, s);
    endtask
endmodule

`default_nettype wire

// ==== setwt_tb_top.sv ====
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module setwt_tb_top;
    localparam int WR_CYC = 300;
    localparam logic [7:0] DEV_W = 8'hAA;
    localparam logic [7:0] DEV_R = 8'hAB;
    typedef struct packed {logic [2:0] strap; logic [7:0] dev; logic nack;} setwt_row_t;
    // Straps, device byte, expected acknowledge level
    // The 011 and 110 strap rows make every strap input move at least once
    setwt_row_t rows [9] = '{{3'b101, 8'hA8, 1'b1}, {3'b101, 8'hA2, 1'b1},
        {3'b101, 8'h2A, 1'b1}, {3'b101, 8'hBA, 1'b1}, {3'b011, 8'hAA, 1'b1},
        {3'b011, 8'hA6, 1'b0}, {3'b110, 8'hAE, 1'b1}, {3'b110, 8'hAC, 1'b0},
        {3'b101, 8'hAA, 1'b0}};
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic srst, scl, host_sda, sda_out, sda_oe_n, wi, prog_busy, ack;
    logic [2:0] strap;
    wire logic sda_w;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int w;

    // Open-drain wire: either party may pull it low
    assign sda_w = host_sda & (sda_oe_n | sda_out);
    always #50 mclk = ~mclk;
    always #7.5 link_clk = ~link_clk;

    setwt_top #(.WR_CYCLES(WR_CYC)) uut (
        .mclk(mclk), .srst(srst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_select_bit_2(strap[2]),
        .strap_select_bit_1(strap[1]), .strap_select_bit_0(strap[0]),
        .write_inhibit(wi), .prog_busy(prog_busy));
    setwt_host host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda(host_sda));

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Repeat Start plus device byte until acknowledged
    task automatic poll(input logic [7:0] dev, input logic busy_exp);
        int k;
        k = 0;
        ack = 1'b1;
        while (ack !== 1'b0 && k < 40) begin
            if (k > 0) host.stop();
            host.start();
            host.put(dev, ack);
            k++;
        end
        `CHK("poll ack", 1'b0, ack)
        if (busy_exp) `CHK("busy nack", 1'b1, k > 1)
    endtask

    task automatic wr(input logic [7:0] wa, input logic [7:0] d[$], input logic busy_exp);
        poll(DEV_W, busy_exp);
        host.put(wa, ack);
        `CHK("addr ack", 1'b0, ack)
        foreach (d[i]) begin
            host.put(d[i], ack);
            `CHK("data ack", wi, ack)
        end
        host.stop();
        `CHK("prog busy", ~wi, prog_busy)
    endtask

    task automatic rd(input logic rnd, input logic [7:0] wa, input logic [7:0] e[$],
        input logic busy_exp);
        logic [7:0] q;
        poll(rnd ? DEV_W : DEV_R, busy_exp);
        if (rnd) begin
            host.put(wa, ack);
            `CHK("addr ack", 1'b0, ack)
            host.start();
            host.put(DEV_R, ack);
            `CHK("read ack", 1'b0, ack)
        end
        foreach (e[i]) begin
            host.get(i == e.size() - 1, q);
            `CHK("read data", e[i], q)
        end
        host.stop();
    endtask

    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        srst = 1'b1;
        strap = 3'b101;
        wi = 1'b0;
        ack = 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        `CHK("idle drive", 1'b1, sda_oe_n)
        `CHK("idle busy", 1'b0, prog_busy)
        `CHK("drive level", 1'b0, sda_out)
        host.step(10);
        // Device address table; wait out any programming a row starts
        foreach (rows[i]) begin
            strap = rows[i].strap;
            host.step(4);
            host.start();
            host.put(rows[i].dev, ack);
            `CHK("dev ack", rows[i].nack, ack)
            host.stop();
            for (w = 0; w < 400 && prog_busy !== 1'b0; w++) host.step(1);
            host.step(2);
            $display("test address row %0d done", i);
        end
        // Ten bytes into an eight byte page: the last two overwrite the first two written
        wr(8'h3C, {8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19},
            1'b0);
        rd(1'b1, 8'h38, {8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h12}, 1'b1);
        rd(1'b0, 8'h00, {8'h13}, 1'b0);
        $display("test page wrap done");
        wi = 1'b1;
        wr(8'hFF, {8'h55}, 1'b0);
        wi = 1'b0;
        wr(8'hFF, {8'h5A}, 1'b0);
        wr(8'h00, {8'hA5}, 1'b1);
        rd(1'b1, 8'hFF, {8'h5A, 8'hA5}, 1'b1);
        $display("test inhibit and read wrap done");
        // Stop after half a byte: only the whole byte lands
        wr(8'h10, {8'h77, 8'h88}, 1'b0);
        poll(DEV_W, 1'b1);
        host.put(8'h10, ack);
        host.put(8'h66, ack);
        for (w = 0; w < 4; w++) host.xfer(1'b0, ack);
        host.stop();
        rd(1'b1, 8'h10, {8'h66, 8'h88}, 1'b1);
        $display("test partial byte done");
        // Second reset clears the counter but keeps the array
        srst = 1'b1;
        host.step(6);
        srst = 1'b0;
        host.step(4);
        rd(1'b0, 8'h00, {8'hA5}, 1'b0);
        $display("test mid reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
